// [verilog/blcur_pkg.sv]
// blcur_pkg: shared constants and types for the backlight level current register bank.
// assumes a byte-wide register port decoded by the serial programming front end.
package blcur_pkg;
    // register byte addresses
    localparam logic [7:0] BLCUR_ADDR_INDOOR_MAX = 8'h10;
    localparam logic [7:0] BLCUR_ADDR_INDOOR_DIM = 8'h11;
    localparam logic [7:0] BLCUR_ADDR_DARK_MAX   = 8'h12;
    localparam logic [7:0] BLCUR_ADDR_DARK_DIM   = 8'h13;
    localparam logic [7:0] BLCUR_ADDR_SINK_LAW   = 8'h1a;

    // field layout
    localparam int         BLCUR_CODE_W      = 7;
    localparam int         BLCUR_LAW_W       = 2;
    localparam logic [7:0] BLCUR_READ_ZERO   = 8'h00;

    // reset values
    localparam logic [6:0] BLCUR_CODE_RESET  = 7'h00;
    localparam logic [1:0] BLCUR_LAW_RESET   = 2'h0;

    // fade-law encodings
    localparam logic [1:0] BLCUR_LAW_SQ_A    = 2'h0;
    localparam logic [1:0] BLCUR_LAW_SQ_B    = 2'h1;
    localparam logic [1:0] BLCUR_LAW_CUBIC_A = 2'h2;
    localparam logic [1:0] BLCUR_LAW_CUBIC_B = 2'h3;

    // current transfer: full scale in microamps at the top code
    localparam logic [31:0] BLCUR_FULL_UA    = 32'h0000_7530; // 30000 uA
    localparam logic [31:0] BLCUR_CODE_MAX_SQ = 32'h0000_3f01; // 127 * 127
    localparam logic [31:0] BLCUR_ROUND_HALF = 32'h0000_1f80; // half of 127 squared, floored

    // fade profile presented to the sink fader
    typedef enum logic [1:0] {
        BLCUR_FADE_SQ_LINEAR,
        BLCUR_FADE_CUBIC_A,
        BLCUR_FADE_CUBIC_B
    } blcur_fade_t;

    // one register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } blcur_req_t;

    // backlight drive result
    typedef struct packed {
        logic [6:0]  code;
        logic [15:0] current_ua;
    } blcur_drive_t;
endpackage : blcur_pkg

// [verilog/blcur_regs.sv]
// blcur_regs: max/dim current codes for the indoor and dark levels plus sink fade law.
// assumes i_req comes from logic on i_clk (no synchroniser); dim and level inputs likewise.
//
// Contract
// - the indoor maximum current is a 7-bit code in bits 6:0, bit 7 reserved.
// - the indoor dim current is a 7-bit code in bits 6:0 of its own register, bit 7 reserved.
// - the dark maximum current is a 7-bit code in bits 6:0, bit 7 reserved.
// - the dark dim current is a 7-bit code in bits 6:0 of its own register, bit 7 reserved.
// - a dim timeout or the dim enable flag selects the active level's dim code over its max.
// - the code maps monotonically to current, zero at code 0 and 30 mA at code 127.
// - the fade-law field is bits 1:0 and codes 00 and 01 both mean square law, equal steps.
// - fade-law codes 10 and 11 mean square law with two distinct cubic time profiles.
// - bits 7:2 of the fade-law register are reserved.
`timescale 1ns/1ns
module blcur_regs
    import blcur_pkg::*;
(
    // clock, reset, enable
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    // register port
    input  wire blcur_req_t   i_req,
    output logic [7:0]        o_rdata,
    output logic              o_rd_valid,
    // level and dim control
    input  wire logic         i_level_dark,
    input  wire logic         i_dim_timeout,
    input  wire logic         i_dim_en,
    // drive outputs
    output blcur_drive_t      o_drive,
    output logic              o_dimmed,
    output blcur_fade_t       o_sink_fade_profile
);

    // square-law code to microamps, rounded to nearest
    function automatic logic [15:0] code_to_ua(input logic [6:0] code);
        logic [31:0] sq;
        sq = 32'(code) * 32'(code);
        code_to_ua = 16'((sq * BLCUR_FULL_UA + BLCUR_ROUND_HALF) / BLCUR_CODE_MAX_SQ);
    endfunction : code_to_ua

    // true for the five byte addresses this bank answers to
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = addr inside {BLCUR_ADDR_INDOOR_MAX, BLCUR_ADDR_INDOOR_DIM,
                                   BLCUR_ADDR_DARK_MAX, BLCUR_ADDR_DARK_DIM,
                                   BLCUR_ADDR_SINK_LAW};
    endfunction : addr_mapped

    logic [6:0]  indoor_max_code_reg;
    logic [6:0]  indoor_dim_code_reg;
    logic [6:0]  dark_max_code_reg;
    logic [6:0]  dark_dim_code_reg;
    logic [1:0]  sink_fade_law_reg;
    logic        dim_sel;
    logic [6:0]  drive_code_next;
    logic [7:0]  rdata_next;
    blcur_fade_t fade_next;

    // current code registers; only bits 6:0 are stored so bit 7 writes vanish
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            indoor_max_code_reg <= BLCUR_CODE_RESET;
            indoor_dim_code_reg <= BLCUR_CODE_RESET;
            dark_max_code_reg   <= BLCUR_CODE_RESET;
            dark_dim_code_reg   <= BLCUR_CODE_RESET;
        end else if (i_ce && i_req.wr) begin
            case (i_req.addr)
                BLCUR_ADDR_INDOOR_MAX: indoor_max_code_reg <= i_req.wdata[6:0];
                BLCUR_ADDR_INDOOR_DIM: indoor_dim_code_reg <= i_req.wdata[6:0];
                BLCUR_ADDR_DARK_MAX:   dark_max_code_reg   <= i_req.wdata[6:0];
                BLCUR_ADDR_DARK_DIM:   dark_dim_code_reg   <= i_req.wdata[6:0];
                default: ;
            endcase
        end
    end

    // fade-law register keeps only the two low bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sink_fade_law_reg <= BLCUR_LAW_RESET;
        end else if (i_ce && i_req.wr && i_req.addr == BLCUR_ADDR_SINK_LAW) begin
            sink_fade_law_reg <= i_req.wdata[1:0];
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    always_comb begin
        rdata_next = BLCUR_READ_ZERO;
        case (i_req.addr)
            BLCUR_ADDR_INDOOR_MAX: rdata_next = {1'b0, indoor_max_code_reg};
            BLCUR_ADDR_INDOOR_DIM: rdata_next = {1'b0, indoor_dim_code_reg};
            BLCUR_ADDR_DARK_MAX:   rdata_next = {1'b0, dark_max_code_reg};
            BLCUR_ADDR_DARK_DIM:   rdata_next = {1'b0, dark_dim_code_reg};
            BLCUR_ADDR_SINK_LAW:   rdata_next = {6'h00, sink_fade_law_reg};
            default:               rdata_next = BLCUR_READ_ZERO;
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata    <= BLCUR_READ_ZERO;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_req.rd;
            if (i_req.rd) begin
                o_rdata <= rdata_next;
            end
        end
    end

    // dim wins over max whenever either dim cause is present
    always_comb begin
        dim_sel = i_dim_timeout | i_dim_en;
        if (i_level_dark) begin
            drive_code_next = dim_sel ? dark_dim_code_reg : dark_max_code_reg;
        end else begin
            drive_code_next = dim_sel ? indoor_dim_code_reg : indoor_max_code_reg;
        end
    end

    // fade-law decode: two codes alias onto the same equal-step profile
    always_comb begin
        case (sink_fade_law_reg)
            BLCUR_LAW_SQ_A:    fade_next = BLCUR_FADE_SQ_LINEAR;
            BLCUR_LAW_SQ_B:    fade_next = BLCUR_FADE_SQ_LINEAR;
            BLCUR_LAW_CUBIC_A: fade_next = BLCUR_FADE_CUBIC_A;
            BLCUR_LAW_CUBIC_B: fade_next = BLCUR_FADE_CUBIC_B;
            default:           fade_next = BLCUR_FADE_SQ_LINEAR;
        endcase
    end

    // registered drive; the divider is deep, so registering keeps it off the output path
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_drive             <= '0;
            o_dimmed            <= 1'b0;
            o_sink_fade_profile <= BLCUR_FADE_SQ_LINEAR;
        end else if (i_ce) begin
            o_drive.code        <= drive_code_next;
            o_drive.current_ua  <= code_to_ua(drive_code_next);
            o_dimmed            <= dim_sel;
            o_sink_fade_profile <= fade_next;
        end
    end

    // checks
    AST_INDOOR_MAX_WR: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.wr && i_req.addr == BLCUR_ADDR_INDOOR_MAX
        |=> indoor_max_code_reg == $past(i_req.wdata[6:0]))
        else $error("indoor max code not stored");

    AST_INDOOR_DIM_WR: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.wr && i_req.addr == BLCUR_ADDR_INDOOR_DIM
        |=> indoor_dim_code_reg == $past(i_req.wdata[6:0]) && $stable(indoor_max_code_reg))
        else $error("indoor dim code not stored separately");

    AST_DARK_MAX_RD: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.rd && i_req.addr == BLCUR_ADDR_DARK_MAX
        |=> o_rd_valid && o_rdata == {1'b0, $past(dark_max_code_reg)})
        else $error("dark max readback wrong");

    AST_DARK_DIM_WR_RD: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.wr && i_req.addr == BLCUR_ADDR_DARK_DIM ##1
        i_ce && !i_req.wr && i_req.rd && i_req.addr == BLCUR_ADDR_DARK_DIM
        |=> o_rdata == {1'b0, $past(i_req.wdata[6:0], 2)})
        else $error("dark dim write then read mismatch");

    AST_DIM_SELECT: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && (i_dim_timeout || i_dim_en) && !i_req.wr
        |=> o_dimmed && o_drive.code ==
            ($past(i_level_dark) ? dark_dim_code_reg : indoor_dim_code_reg))
        else $error("dim code not selected");

    AST_MAX_SELECT: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !i_dim_timeout && !i_dim_en && !i_req.wr
        |=> !o_dimmed && o_drive.code ==
            ($past(i_level_dark) ? dark_max_code_reg : indoor_max_code_reg))
        else $error("max code not selected");

    AST_CURRENT_ENDS: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce) && !$past(i_rst) |->
        (o_drive.code == 7'h00 ? o_drive.current_ua == 16'h0000 : 1'b1) &&
        (o_drive.code == 7'h7f ? o_drive.current_ua == 16'h7530 : 1'b1))
        else $error("current end points wrong");

    AST_LAW_ALIAS: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !i_req.wr && sink_fade_law_reg[1] == 1'b0
        |=> o_sink_fade_profile == BLCUR_FADE_SQ_LINEAR)
        else $error("law 00/01 not square equal-step");

    AST_LAW_CUBIC: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !i_req.wr && sink_fade_law_reg[1]
        |=> o_sink_fade_profile == ($past(sink_fade_law_reg[0]) ?
            BLCUR_FADE_CUBIC_B : BLCUR_FADE_CUBIC_A))
        else $error("cubic profile mismatch");

    AST_LAW_RESERVED: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.rd && i_req.addr == BLCUR_ADDR_SINK_LAW
        |=> o_rdata[7:2] == 6'h00)
        else $error("law reserved bits not zero");

    AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rd_valid |-> o_rdata[7] == 1'b0)
        else $error("reserved bit 7 reads one");

    // holes in the map answer like a register that reads zero
    AST_UNMAPPED_RD: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.rd && !addr_mapped(i_req.addr)
        |=> o_rd_valid && o_rdata == BLCUR_READ_ZERO)
        else $error("unmapped read not zero");

    AST_UNMAPPED_WR: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.wr && !addr_mapped(i_req.addr)
        |=> $stable(indoor_max_code_reg) && $stable(indoor_dim_code_reg) &&
            $stable(dark_max_code_reg) && $stable(dark_dim_code_reg) &&
            $stable(sink_fade_law_reg))
        else $error("unmapped write disturbed a register");

    // a larger code never gives less current, so a fade cannot step backwards
    AST_CURRENT_MONO: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_ce) && !$past(i_rst) && o_drive.code > $past(o_drive.code)
        |-> o_drive.current_ua >= $past(o_drive.current_ua))
        else $error("current not monotonic in code");

    COV_DIM_DARK: cover property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_level_dark && i_dim_timeout ##1 o_dimmed);
    COV_CUBIC_B: cover property (@(posedge i_clk) disable iff (i_rst)
        o_sink_fade_profile == BLCUR_FADE_CUBIC_B);
    COV_FULL_SCALE: cover property (@(posedge i_clk) disable iff (i_rst)
        o_drive.code == 7'h7f);
    COV_WR_THEN_RD: cover property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.wr ##1 i_ce && i_req.rd ##1 o_rd_valid);
endmodule : blcur_regs

// [sim/tb_blcur_regs.sv]
// tb_blcur_regs: self-checking bench for the backlight level current register bank.
// assumes blcur_pkg and blcur_regs are compiled first; one 50 MHz clock, async reset.
`timescale 1ns/1ns
module tb_blcur_regs
    import blcur_pkg::*;
;
    // design signals
    logic         i_clk, i_rst, i_ce, i_level_dark, i_dim_timeout, i_dim_en;
    blcur_req_t   i_req;
    logic [7:0]   o_rdata;
    logic         o_rd_valid;
    blcur_drive_t o_drive;
    logic         o_dimmed;
    blcur_fade_t  o_sink_fade_profile;
    // bench state: expected read data and a shadow of the registers
    logic [7:0]   exp_q[$];
    logic [6:0]   code_m[4];
    logic [1:0]   law_m;
    int           mismatches, compares;

    blcur_regs blcur_regs_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req),
        .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .i_level_dark(i_level_dark),
        .i_dim_timeout(i_dim_timeout), .i_dim_en(i_dim_en), .o_drive(o_drive),
        .o_dimmed(o_dimmed), .o_sink_fade_profile(o_sink_fade_profile));

    // free-running 50 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one request per edge; the next call replaces it at the edge that takes it
    task automatic op(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{wr: wr, rd: rd, addr: a, wdata: d};
        if (rd) exp_q.push_back((a >= 8'h10 && a <= 8'h13) ? {1'b0, code_m[a[1:0]]} :
                                (a == 8'h1a) ? {6'h00, law_m} : 8'h00);
        // shadow only mapped writes that are really taken; reserved bits drop out
        if (wr && i_ce && a >= 8'h10 && a <= 8'h13) code_m[a[1:0]] = d[6:0];
        if (wr && i_ce && a == 8'h1a) law_m = d[1:0];
    endtask : op

    task automatic idle();
        @(posedge i_clk);
        i_req <= '0;
    endtask : idle

    // drive path settles at the same enabled edge that takes the inputs
    task automatic drive_chk(input logic dark, input logic tmo, input logic en);
        logic [6:0]  c;
        int unsigned ua;
        @(posedge i_clk);
        i_level_dark  <= dark;
        i_dim_timeout <= tmo;
        i_dim_en      <= en;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        c  = code_m[{dark, tmo | en}];
        ua = (30000 * c * c + 8064) / 16129; // rounded square law
        check(32'(o_drive.code), 32'(c));
        check(32'(o_drive.current_ua), ua);
        check(32'(o_dimmed), 32'(tmo | en));
    endtask : drive_chk

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // read monitor: each valid pulse retires the oldest expectation
    always @(negedge i_clk) begin
        if (o_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("unexpected at %0t: read data with nothing pending", $time);
            end else
                check(32'(o_rdata), 32'(exp_q.pop_front()));
        end
    end

    // watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end

    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_req = '0;
        {i_level_dark, i_dim_timeout, i_dim_en} = 3'h0;
        mismatches = 0;
        compares = 0;
        code_m = '{default: 7'h00};
        law_m = 2'h0;
        void'($urandom(12691));
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        // outputs sit at their reset values at the first edge after release
        @(negedge i_clk);
        check({8'h00, o_drive, o_dimmed}, 32'h0000_0000);
        check(32'(o_sink_fade_profile), 32'(BLCUR_FADE_SQ_LINEAR));
        // reset values, plus unmapped addresses around the map
        for (int a = 16; a <= 27; a++) op(1'b0, 1'b1, 8'(a), 8'h00);
        // random codes with the reserved bit set, written and read back to back
        for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 8'(16 + i), 8'h80 | 8'($urandom));
        for (int i = 0; i < 4; i++) op(1'b0, 1'b1, 8'(16 + i), 8'h00);
        // every fade-law code with junk in the reserved bits
        for (int l = 0; l < 4; l++) begin
            op(1'b1, 1'b0, 8'h1a, {6'($urandom), 2'(l)});
            op(1'b0, 1'b1, 8'h1a, 8'h00);
            idle();
            @(negedge i_clk);
            check(32'(o_sink_fade_profile), (l < 2) ? 32'(BLCUR_FADE_SQ_LINEAR) :
                  (l == 2) ? 32'(BLCUR_FADE_CUBIC_A) : 32'(BLCUR_FADE_CUBIC_B));
        end
        // code end points; an unmapped write must not disturb the map
        op(1'b1, 1'b0, 8'h10, 8'h7f);
        op(1'b1, 1'b0, 8'h11, 8'h00);
        op(1'b1, 1'b0, 8'h14, 8'hff);
        op(1'b0, 1'b1, 8'h10, 8'h00);
        op(1'b0, 1'b1, 8'h11, 8'h00);
        // a read right behind a write sees the new code; one beside it sees the old
        op(1'b1, 1'b0, 8'h13, 8'($urandom));
        op(1'b0, 1'b1, 8'h13, 8'h00);
        op(1'b1, 1'b1, 8'h12, 8'($urandom));
        op(1'b0, 1'b1, 8'h12, 8'h00);
        idle();
        // a write while the clock enable is low is not taken
        @(posedge i_clk) i_ce <= 1'b0;
        op(1'b1, 1'b0, 8'h12, 8'h55);
        idle();
        @(posedge i_clk) i_ce <= 1'b1;
        op(1'b0, 1'b1, 8'h12, 8'h00);
        idle();
        // both levels against every dim source combination
        for (int m = 0; m < 8; m++) drive_chk(m[2], m[0], m[1]);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge i_clk);
        if (exp_q.size() > 0) begin
            mismatches++;
            $display("unexpected at %0t: reads left unanswered", $time);
        end
        conclude();
    end
endmodule : tb_blcur_regs
